// [mssr_consts.svh]
// constants of the misc status and shadow register slice
`ifndef MSSR_CONSTS_SVH
`define MSSR_CONSTS_SVH
// register indices, byte address is four times the index
`define MSSR_IDX_EVT    6'h1C
`define MSSR_IDX_U2FC   6'h1D
`define MSSR_IDX_FORCE  6'h1E
`define MSSR_IDX_RATE   6'h1F
`define MSSR_IDX_U1FC   6'h20
`define MSSR_IDX_MASK   6'h21
// reset values
`define MSSR_RST_EVT    6'h00
`define MSSR_RST_U2FC   8'h00
`define MSSR_RST_FORCE  2'h3
`define MSSR_RST_RATE   8'h02
`define MSSR_RST_U1FC   8'h00
`define MSSR_RST_MASK   6'h00
// field layout
`define MSSR_EVT_W      6
`define MSSR_FORCE_D0   0
`define MSSR_FORCE_D1   1
`define MSSR_U2FC_RMASK 8'hCF
`define MSSR_RATE_RMASK 8'hDF
// settle cycles after reset before edges count
`define MSSR_PRIME_CYC  2'h3
`endif

// [mssr_drive_model.sv]
// far-side floppy drive model: selects, step and media change
`timescale 1ns/1ps
`default_nettype none
module mssr_drive_model (
	input  wire logic       pclk,            // bench clock
	input  wire logic       presetn,         // async reset, active low
	input  wire logic [1:0] sel_req,         // 1 drive 0, 2 drive 1, 0 none
	input  wire logic       step_req,        // step toward selected drive
	input  wire logic       chg_req,         // drive reports media change
	output logic            drive0_select,   // drive 0 selected
	output logic            drive1_select,   // drive 1 selected
	output logic            step_pulse_out,  // step active
	output logic            media_changed_in // media changed
);
	// one select at a time; a step only passes while sel_req is nonzero, so also with sel_req 3 and no drive selected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{drive0_select, drive1_select, step_pulse_out, media_changed_in} <= 4'h0;
		end else begin
			drive0_select    <= (sel_req == 2'h1);
			drive1_select    <= (sel_req == 2'h2);
			step_pulse_out   <= step_req & (sel_req != 2'h0);
			media_changed_in <= chg_req;
		end
	end
endmodule
`default_nettype wire

// [mssr_pkg.sv]
// types of the misc status and shadow register slice
package mssr_pkg;
	// apb slave states, one-hot
	typedef enum logic [1:0] {
		MSSR_ST_IDLE = 2'b01, // waiting for an access phase
		MSSR_ST_RESP = 2'b10  // pready high, transfer completes
	} mssr_state_t;
	typedef logic [7:0] mssr_byte_t; // one register byte
endpackage

// [mssr_top.sv]
// misc event status, serial and floppy shadow registers behind apb
`timescale 1ns/1ps
`default_nettype none
`include "mssr_consts.svh"
module mssr_top (
	input  wire logic        pclk,                   // apb clock, 100 MHz
	input  wire logic        presetn,                // async reset, active low
	input  wire logic        psel,                   // apb select
	input  wire logic        penable,                // apb access phase
	input  wire logic        pwrite,                 // apb direction
	input  wire logic [7:0]  paddr,                  // apb byte address
	input  wire logic [31:0] pwdata,                 // apb write data
	output logic      [31:0] prdata,                 // apb read data
	output logic             pready,                 // apb ready
	output logic             pslverr,                // apb error, unmapped index
	input  wire logic [5:0]  edge_pin,               // edge_pin_0..edge_pin_5
	input  wire logic        uart2_fifo_ctrl_we,     // second serial fcr write strobe
	input  wire logic [7:0]  uart2_fifo_ctrl_wdata,  // second serial fcr value
	input  wire logic        uart1_fifo_ctrl_we,     // first serial fcr write strobe
	input  wire logic [7:0]  uart1_fifo_ctrl_wdata,  // first serial fcr value
	input  wire logic        floppy_rate_we,         // floppy rate select write strobe
	input  wire logic [7:0]  floppy_rate_wdata,      // floppy rate select value
	input  wire logic        step_pulse_out,         // drive step active
	input  wire logic        drive0_select,          // drive 0 selected
	input  wire logic        drive1_select,          // drive 1 selected
	input  wire logic        media_changed_in,       // drive media changed
	output logic             media_changed_bit,      // bit 7 of floppy_digital_input_reg
	output logic             irq                     // unmasked event pending, level
);
	// apb state
	mssr_pkg::mssr_state_t st_r, st_nxt;       // slave phase
	logic [31:0]           prdata_r, prdata_nxt; // read data
	logic                  pready_r, pready_nxt; // ready
	logic                  perr_r, perr_nxt;    // error
	// register state
	logic [5:0]            evt_r, evt_nxt;      // event status
	logic [5:0]            mask_r, mask_nxt;    // event mask
	logic [1:0]            force_r, force_nxt;  // force change per drive
	mssr_pkg::mssr_byte_t  u2fc_r, u2fc_nxt;    // second serial mirror
	mssr_pkg::mssr_byte_t  u1fc_r, u1fc_nxt;    // first serial mirror
	mssr_pkg::mssr_byte_t  rate_r, rate_nxt;    // floppy rate mirror
	logic                  media_r, media_nxt;  // media changed output
	logic                  irq_r, irq_nxt;      // interrupt output
	// pin sampling
	logic [5:0]            sync1_r, sync2_r, prev_r; // synchroniser and history
	logic [1:0]            prime_r, prime_nxt;  // settle counter after reset
	logic [5:0]            edge_det;            // one-cycle edge pulses
	// decode
	logic [5:0]            idx;                 // register index
	logic                  hit;                 // index is mapped
	logic                  wr_go;               // write takes effect now
	logic                  step0, step1;        // per drive clear terms
	mssr_pkg::mssr_byte_t  rd_byte;             // selected read value

	assign idx   = paddr[7:2];
	assign wr_go = psel && penable && pwrite && pready_r;
	assign step0 = step_pulse_out && drive0_select;
	assign step1 = step_pulse_out && drive1_select;

	// index decode and read mux
	always_comb begin
		hit     = 1'b1;
		rd_byte = 8'h00;
		unique case (idx)
			`MSSR_IDX_EVT:   rd_byte = {2'h0, evt_r};
			`MSSR_IDX_U2FC:  rd_byte = u2fc_r & `MSSR_U2FC_RMASK;
			`MSSR_IDX_FORCE: rd_byte = {6'h00, force_r};
			`MSSR_IDX_RATE:  rd_byte = rate_r & `MSSR_RATE_RMASK;
			`MSSR_IDX_U1FC:  rd_byte = u1fc_r & `MSSR_U2FC_RMASK;
			`MSSR_IDX_MASK:  rd_byte = {2'h0, mask_r};
			default:         hit     = 1'b0;                       // unmapped index
		endcase
	end

	// apb slave: one wait cycle, then pready for exactly one cycle
	always_comb begin
		st_nxt     = st_r;
		prdata_nxt = prdata_r;
		pready_nxt = 1'b0;
		perr_nxt   = 1'b0;
		unique case (st_r)
			mssr_pkg::MSSR_ST_IDLE: begin
				if (psel && penable) begin // access phase seen
					st_nxt     = mssr_pkg::MSSR_ST_RESP;
					pready_nxt = 1'b1;
					perr_nxt   = !hit;
					prdata_nxt = (pwrite || !hit) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
				end
			end
			mssr_pkg::MSSR_ST_RESP: begin // transfer completes this edge
				st_nxt     = mssr_pkg::MSSR_ST_IDLE;
				prdata_nxt = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r     <= mssr_pkg::MSSR_ST_IDLE;
			prdata_r <= 32'h0000_0000;
			pready_r <= 1'b0;
			perr_r   <= 1'b0;
		end else begin
			st_r     <= st_nxt;
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			perr_r   <= perr_nxt;
		end
	end

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = perr_r;

	// pin synchroniser, only sync2 reads sync1
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 6'h00;
			sync2_r <= 6'h00;
			prev_r  <= 6'h00;
		end else begin
			sync1_r <= edge_pin;
			sync2_r <= sync1_r;
			prev_r  <= sync2_r;
		end
	end

	// hold off edges until history holds real pin levels
	always_comb begin
		prime_nxt = (prime_r == `MSSR_PRIME_CYC) ? prime_r : prime_r + 2'h1;
		edge_det  = (prime_r == `MSSR_PRIME_CYC) ? (sync2_r ^ prev_r) : 6'h00;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prime_r <= 2'h0;
		end else begin
			prime_r <= prime_nxt;
		end
	end

	// register next values
	always_comb begin
		evt_nxt   = evt_r;
		mask_nxt  = mask_r;
		force_nxt = force_r;
		u2fc_nxt  = u2fc_r;
		u1fc_nxt  = u1fc_r;
		rate_nxt  = rate_r;
		// write-one clear, edges applied after so they win
		if (wr_go && idx == `MSSR_IDX_EVT) begin
			evt_nxt = evt_r & ~pwdata[5:0];
		end
		evt_nxt = evt_nxt | edge_det;
		if (wr_go && idx == `MSSR_IDX_MASK) begin
			mask_nxt = pwdata[5:0];
		end
		// step clears, software set applied after so it wins
		if (step0) begin
			force_nxt[`MSSR_FORCE_D0] = 1'b0;
		end
		if (step1) begin
			force_nxt[`MSSR_FORCE_D1] = 1'b0;
		end
		if (wr_go && idx == `MSSR_IDX_FORCE) begin
			force_nxt = force_nxt | pwdata[1:0];
		end
		// mirrors follow the serial and floppy write strobes
		if (uart2_fifo_ctrl_we) begin
			u2fc_nxt = uart2_fifo_ctrl_wdata;
		end
		if (uart1_fifo_ctrl_we) begin
			u1fc_nxt = uart1_fifo_ctrl_wdata;
		end
		if (floppy_rate_we) begin
			rate_nxt = floppy_rate_wdata;
		end
		// irq from the next state, media bit from the current force_r
		media_nxt = (drive0_select && force_r[`MSSR_FORCE_D0]) ||
		            (drive1_select && force_r[`MSSR_FORCE_D1]) || media_changed_in;
		irq_nxt   = |(evt_nxt & mask_nxt);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_r   <= `MSSR_RST_EVT;
			mask_r  <= `MSSR_RST_MASK;
			force_r <= `MSSR_RST_FORCE;
			u2fc_r  <= `MSSR_RST_U2FC;
			u1fc_r  <= `MSSR_RST_U1FC;
			rate_r  <= `MSSR_RST_RATE;
			media_r <= 1'b0;
			irq_r   <= 1'b0;
		end else begin
			evt_r   <= evt_nxt;
			mask_r  <= mask_nxt;
			force_r <= force_nxt;
			u2fc_r  <= u2fc_nxt;
			u1fc_r  <= u1fc_nxt;
			rate_r  <= rate_nxt;
			media_r <= media_nxt;
			irq_r   <= irq_nxt;
		end
	end

	assign media_changed_bit = media_r;
	assign irq               = irq_r;

	// write of zeros never clears an event bit
	property p_w1c_zero;
		@(posedge pclk) disable iff (!presetn)
		(wr_go && idx == `MSSR_IDX_EVT && pwdata[5:0] == 6'h00) |=> (($past(evt_r) & ~evt_r) == 6'h00);
	endproperty
	a_w1c_zero: assert property (p_w1c_zero) else $error("event bit lost on zero write");

	// write of ones clears exactly those bits when no edge
	property p_w1c_one;
		@(posedge pclk) disable iff (!presetn)
		(wr_go && idx == `MSSR_IDX_EVT && edge_det == 6'h00) |=> (evt_r == ($past(evt_r) & ~$past(pwdata[5:0])));
	endproperty
	a_w1c_one: assert property (p_w1c_one) else $error("event clear wrong");

	// pin toggle sets its own bit three cycles later, even under clear
	property p_edge_set;
		@(posedge pclk) disable iff (!presetn)
		(prime_r == `MSSR_PRIME_CYC && $changed(sync2_r)) |=> ((evt_r & $past(sync2_r ^ prev_r)) == $past(sync2_r ^ prev_r));
	endproperty
	a_edge_set: assert property (p_edge_set) else $error("edge did not set status");

	// reserved event bits read zero
	property p_evt_rsvd;
		@(posedge pclk) disable iff (!presetn)
		(pready_r && !pwrite && idx == `MSSR_IDX_EVT) |-> (prdata_r[31:6] == 26'h0);
	endproperty
	a_evt_rsvd: assert property (p_evt_rsvd) else $error("event reserved bits set");

	// mirror reports last strobe value, reserved bits masked
	property p_u2fc;
		@(posedge pclk) disable iff (!presetn)
		uart2_fifo_ctrl_we |=> (u2fc_r == $past(uart2_fifo_ctrl_wdata)) && (rd_byte[5:4] == 2'h0 || idx != `MSSR_IDX_U2FC);
	endproperty
	a_u2fc: assert property (p_u2fc) else $error("serial mirror wrong");

	// software write never clears a force bit without step
	property p_force_keep;
		@(posedge pclk) disable iff (!presetn)
		(!step_pulse_out) |=> (($past(force_r) & ~force_r) == 2'h0);
	endproperty
	a_force_keep: assert property (p_force_keep) else $error("force bit cleared without step");

	// step with drive 0 selected and no set clears its force bit
	property p_force_step;
		@(posedge pclk) disable iff (!presetn)
		(step0 && !(wr_go && idx == `MSSR_IDX_FORCE && pwdata[0])) |=> !force_r[`MSSR_FORCE_D0];
	endproperty
	a_force_step: assert property (p_force_step) else $error("step did not clear force");

	// step with drive 1 selected and no set clears its force bit
	property p_force_step1;
		@(posedge pclk) disable iff (!presetn)
		(step1 && !(wr_go && idx == `MSSR_IDX_FORCE && pwdata[1])) |=> !force_r[`MSSR_FORCE_D1];
	endproperty
	a_force_step1: assert property (p_force_step1) else $error("step did not clear drive 1 force");

	// media bit is the registered or of its three terms
	property p_media;
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (media_changed_bit == (($past(drive0_select) && $past(force_r[0])) ||
		          ($past(drive1_select) && $past(force_r[1])) || $past(media_changed_in)));
	endproperty
	a_media: assert property (p_media) else $error("media bit wrong");

	// rate mirror keeps bit 5 zero on reads
	property p_rate_rsvd;
		@(posedge pclk) disable iff (!presetn)
		(pready_r && !pwrite && idx == `MSSR_IDX_RATE) |-> (prdata_r[5] == 1'b0);
	endproperty
	a_rate_rsvd: assert property (p_rate_rsvd) else $error("rate reserved bit set");

	// interrupt follows unmasked status
	property p_irq_level;
		@(posedge pclk) disable iff (!presetn)
		irq == |(evt_r & mask_r);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

	// pready lasts exactly one cycle
	property p_ready_pulse;
		@(posedge pclk) disable iff (!presetn)
		pready_r |=> !pready_r;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
endmodule
`default_nettype wire

// [mssr_top_tb.sv]
// self-checking bench of the misc status and shadow registers
`timescale 1ns/1ps
`default_nettype none
module mssr_top_tb;
	logic        pclk;      // apb clock
	logic        presetn;   // reset, active low
	logic        psel;      // apb select
	logic        penable;   // apb access phase
	logic        pwrite;    // apb direction
	logic [7:0]  paddr;     // apb address
	logic [31:0] pwdata;    // apb write data
	logic [31:0] prdata;    // apb read data
	logic        pready;    // apb ready
	logic        pslverr;   // apb error
	logic [5:0]  edge_pin;  // event pins
	logic [2:0]  mir_we;    // strobes: uart2, uart1, rate
	logic [7:0]  mir_wd;    // shared mirror value
	logic [1:0]  sel_req;   // drive select request
	logic        step_req;  // step request
	logic        chg_req;   // media change request
	logic        d0_sel;    // drive 0 select
	logic        d1_sel;    // drive 1 select
	logic        step;      // step pulse
	logic        chg_in;    // media changed input
	logic        media_bit; // media changed bit
	logic        irq;       // level interrupt
	logic [31:0] rd;        // last read data
	logic        err;       // last error flag
	int          errors = 0;
	int          n_tests = 0;
	int          i;
	// rows: strobe, value, address, expected read
	logic [26:0] rows [10] = '{{3'h0, 8'h00, 8'h70, 8'h00}, {3'h0, 8'h00, 8'h74, 8'h00},
		{3'h0, 8'h00, 8'h78, 8'h03}, {3'h0, 8'h00, 8'h7C, 8'h02}, {3'h0, 8'h00, 8'h80, 8'h00},
		{3'h0, 8'h00, 8'h84, 8'h00}, {3'h1, 8'hFF, 8'h74, 8'hCF}, {3'h1, 8'h41, 8'h74, 8'h41},
		{3'h2, 8'hFF, 8'h80, 8'hCF}, {3'h4, 8'hA5, 8'h7C, 8'h85}};
	mssr_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.edge_pin(edge_pin), .uart2_fifo_ctrl_we(mir_we[0]), .uart2_fifo_ctrl_wdata(mir_wd),
		.uart1_fifo_ctrl_we(mir_we[1]), .uart1_fifo_ctrl_wdata(mir_wd), .floppy_rate_we(mir_we[2]),
		.floppy_rate_wdata(mir_wd), .step_pulse_out(step), .drive0_select(d0_sel),
		.drive1_select(d1_sel), .media_changed_in(chg_in), .media_changed_bit(media_bit), .irq(irq));
	mssr_drive_model drive (.pclk(pclk), .presetn(presetn), .sel_req(sel_req), .step_req(step_req),
		.chg_req(chg_req), .drive0_select(d0_sel), .drive1_select(d1_sel), .step_pulse_out(step),
		.media_changed_in(chg_in));
	// compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			errors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one apb transfer, entered right after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// read and compare
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask
	// verdict and end of run
	task print_verdict;
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always #5 pclk = ~pclk;
	// watchdog against a hang
	initial begin
		repeat (5000) @(posedge pclk);
		errors++;
		print_verdict();
	end
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{edge_pin, mir_we, mir_wd, sel_req, step_req, chg_req} = '0;
		tick(8);
		presetn <= 1'b1;
		tick(1);
		// reset values, then mirror loads read back masked
		for (i = 0; i < 10; i++) begin
			if (rows[i][26:24] != 3'h0) begin
				mir_we <= rows[i][26:24];
				mir_wd <= rows[i][23:16];
				tick(1);
				mir_we <= 3'h0;
				tick(1);
			end
			rdchk(rows[i][15:8], {24'h0, rows[i][7:0]});
		end
		apb(1'b1, 8'h74, 32'hFF);
		rdchk(8'h74, 32'h41);
		apb(1'b0, 8'h88, 32'h0);
		chk({31'h0, err}, 32'h1);
		// rising edge on each pin, status accumulates
		for (i = 0; i < 6; i++) begin
			edge_pin[i] <= 1'b1;
			tick(6);
			rdchk(8'h70, (32'h2 << i) - 32'h1);
		end
		apb(1'b1, 8'h70, 32'hD5);
		rdchk(8'h70, 32'h2A);
		edge_pin <= 6'h0;
		tick(6);
		rdchk(8'h70, 32'h3F);
		// zeros in the low bits keep every status bit
		apb(1'b1, 8'h70, 32'hC0);
		rdchk(8'h70, 32'h3F);
		apb(1'b1, 8'h70, 32'hFF);
		rdchk(8'h70, 32'h0);
		// edge lands in the very cycle of its clear, edge wins
		edge_pin[1] <= 1'b1;
		apb(1'b1, 8'h70, 32'h2);
		rdchk(8'h70, 32'h2);
		// interrupt raised, masked, unmasked, cleared
		apb(1'b1, 8'h84, 32'h1);
		edge_pin[0] <= 1'b1;
		tick(6);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 8'h84, 32'h0);
		tick(1);
		chk({31'h0, irq}, 32'h0);
		apb(1'b1, 8'h84, 32'h1);
		tick(1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b1, 8'h70, 32'h1);
		tick(1);
		chk({31'h0, irq}, 32'h0);
		// forced change per drive, cleared by step
		sel_req <= 2'h1;
		tick(3);
		chk({31'h0, media_bit}, 32'h1);
		step_req <= 1'b1;
		tick(2);
		step_req <= 1'b0;
		tick(2);
		rdchk(8'h78, 32'h2);
		chk({31'h0, media_bit}, 32'h0);
		apb(1'b1, 8'h78, 32'h0);
		rdchk(8'h78, 32'h2);
		sel_req <= 2'h2;
		tick(3);
		chk({31'h0, media_bit}, 32'h1);
		step_req <= 1'b1;
		tick(2);
		step_req <= 1'b0;
		tick(2);
		rdchk(8'h78, 32'h0);
		apb(1'b1, 8'h78, 32'hFF);
		rdchk(8'h78, 32'h3);
		sel_req <= 2'h0;
		chg_req <= 1'b1;
		tick(3);
		chk({31'h0, media_bit}, 32'h1);
		chg_req <= 1'b0;
		tick(3);
		chk({31'h0, media_bit}, 32'h0);
		// second reset in mid-run
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		tick(1);
		rdchk(8'h74, 32'h0);
		rdchk(8'h78, 32'h3);
		rdchk(8'h70, 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
